// ### rtl/vbi_pkg.sv
package vbi_pkg;

	// ************************************************************
	// register map (index on the plain register port)
	// ************************************************************
	localparam int           ADDR_W        = 4;
	localparam logic [3:0]   REG_CAP_DATA0 = 4'h0;
	localparam logic [3:0]   REG_CAP_DATA1 = 4'h1;
	localparam logic [3:0]   REG_EXT_DATA0 = 4'h2;
	localparam logic [3:0]   REG_EXT_DATA1 = 4'h3;
	localparam logic [3:0]   REG_COPY_ZERO = 4'h4;
	localparam logic [3:0]   REG_COPY_ONE  = 4'h5;
	localparam logic [3:0]   REG_COPY_TWO  = 4'h6;
	localparam logic [3:0]   REG_CTRL      = 4'h7;
	localparam logic [3:0]   REG_STATUS    = 4'h8;

	// field positions
	localparam int           CRC_AUTO_BIT  = 4;
	localparam int           ODD_EN_BIT    = 5;
	localparam int           EVEN_EN_BIT   = 6;
	localparam int           CTRL_NTSC_BIT = 0;
	localparam logic [7:0]   CTRL_RESET    = 8'h01;
	localparam logic [7:0]   DATA_RESET    = 8'h00;

	// ************************************************************
	// line numbers and word shapes
	// ************************************************************
	localparam logic [9:0]   LINE_CAP_ODD   = 10'd21;
	localparam logic [9:0]   LINE_CAP_EVEN  = 10'd284;
	localparam logic [9:0]   LINE_COPY_ODD  = 10'd20;
	localparam logic [9:0]   LINE_COPY_EVEN = 10'd283;
	localparam int           RUNIN_BITS    = 7;
	localparam int           CAP_START_IDX = 9;
	localparam int           CAP_WORD_W    = 26;
	localparam int           COPY_WORD_W   = 21;
	localparam int           CRC_DATA_W    = 14;
	localparam logic [5:0]   CRC_PRESET    = 6'h3f;
	localparam logic [5:0]   CRC_POLY      = 6'h03;

	// ************************************************************
	// timing: figures in ns, counts derived from the clock rate
	// ************************************************************
	localparam int CLK_MHZ        = 125;
	localparam int CAP_BIT_NS     = 1986;
	localparam int CAP_START_NS   = 10500;
	localparam int COPY_BIT_NS    = 2235;
	localparam int COPY_START_NS  = 11200;
	localparam int CAP_BIT_CYC    = CAP_BIT_NS * CLK_MHZ / 1000;
	localparam int CAP_START_CYC  = CAP_START_NS * CLK_MHZ / 1000;
	localparam int COPY_BIT_CYC   = COPY_BIT_NS * CLK_MHZ / 1000;
	localparam int COPY_START_CYC = COPY_START_NS * CLK_MHZ / 1000;
	localparam int LINE_TMR_W     = 12;

	// output levels in encoder code units
	localparam logic [7:0]   LVL_BLANK     = 8'h10;
	localparam logic [7:0]   LVL_CAP_HIGH  = 8'h7e;
	localparam logic [7:0]   LVL_COPY_HIGH = 8'h9a;

	// one cycle of the run-in sine, eight phases between blank and high
	function automatic logic [7:0] sine_level(input logic [2:0] ph);
		case (ph)
			3'h0: sine_level = 8'h47;
			3'h1: sine_level = 8'h6c;
			3'h2: sine_level = 8'h7e;
			3'h3: sine_level = 8'h6c;
			3'h4: sine_level = 8'h47;
			3'h5: sine_level = 8'h22;
			3'h6: sine_level = 8'h10;
			default: sine_level = 8'h22;
		endcase
	endfunction

	// crc over c0..c13, c0 first, x^6+x+1, preset all ones
	function automatic logic [5:0] crc6(input logic [13:0] d);
		logic [5:0] c;
		logic       fb;
		c = CRC_PRESET;
		for (int i = 0; i < CRC_DATA_W; i++) begin
			fb = d[i] ^ c[5];
			c = {c[4:0], 1'b0} ^ (fb ? CRC_POLY : 6'h00);
		end
		crc6 = c;
	endfunction

endpackage

// ### rtl/vbi_bit_sender.sv
`timescale 1ns/1ps
module vbi_bit_sender #(
	parameter int W      = 26,
	parameter int PERIOD = 248
) (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 reset_n,
	// word to send, bit 0 first
	input  wire logic                 start,
	input  wire logic [W-1:0]         bits,
	// progress
	output logic                      busy_r,
	output logic [$clog2(W)-1:0]      idx_r,
	output logic [2:0]                phase_r,
	output logic                      curBit
);
	localparam int IW   = $clog2(W);
	localparam int CW   = $clog2(PERIOD);
	localparam int PER8 = PERIOD / 8;

	// a period under eight cycles leaves no room for the eight sine phases
	if (PERIOD < 8 || W < 2) begin : gen_param_check
		$error("vbi_bit_sender: PERIOD or W too small");
	end

	logic [W-1:0]  word_r;
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] sub_r;
	logic          bitEnd;
	logic          subEnd;

	assign bitEnd = cnt_r == CW'(PERIOD - 1);
	assign subEnd = sub_r == CW'(PER8 - 1);
	assign curBit = word_r[idx_r];

	// ************************************************************
	// bit timer and index
	// ************************************************************
	// ascending order out
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			busy_r <= 1'b0;
			idx_r  <= '0;
			cnt_r  <= '0;
			word_r <= '0;
		end else if (start && !busy_r) begin
			busy_r <= 1'b1;
			idx_r  <= '0;
			cnt_r  <= '0;
			word_r <= bits;
		end else if (busy_r) begin
			cnt_r <= bitEnd ? '0 : cnt_r + 1'b1;
			if (bitEnd) begin
				// index parks at zero so the next start shows no jump
				if (idx_r == IW'(W - 1)) begin
					busy_r <= 1'b0;
					idx_r  <= '0;
				end else begin
					idx_r <= idx_r + 1'b1;
				end
			end
		end
	end

	// eighth-of-bit phase for the run-in sine; saturates so a ragged
	// period never wraps the sine early
	always_ff @(posedge clk) begin
		if (!reset_n || !busy_r || bitEnd) begin
			sub_r   <= '0;
			phase_r <= 3'h0;
		end else begin
			sub_r <= subEnd ? '0 : sub_r + 1'b1;
			if (subEnd && phase_r != 3'h7) phase_r <= phase_r + 1'b1;
		end
	end

	// each bit lasts exactly one period
	bit_period_a: assert property (@(posedge clk) disable iff (!reset_n)
		busy_r && $changed(idx_r) |-> $past(cnt_r) == CW'(PERIOD - 1))
		else $error("bit index moved before a full bit period");

endmodule // vbi_bit_sender

// ### rtl/vbi_caption_copy_inserter.sv
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ps
// Behaviour
// - caption data goes on line 21 odd fields and line 284 even fields
// - each caption line opens with a seven-cycle sine run-in at bit rate
// - two blank bit periods after run-in, then a start bit of one
// - sixteen data bits: two bytes, seven data bits plus odd parity
// - line 21 bytes come from caption data registers zero and one
// - line 284 bytes come from extended caption registers zero and one
// - caption lines are generated inside; pixel input is ignored there
// - one byte deep per register; loaded bytes go on the next line
// - copy word on line 20 odd, 283 even, each gated by its enable
// - copy word only in NTSC, never in PAL
// - twenty-bit copy word after a reference pulse one bit long
// - copy bits: reg zero low nibble C16-19, reg one C8-15, reg two C0-7
// - crc-auto set: C14-C19 computed as crc over C0-C13
// - crc polynomial x^6+x+1, preset all ones per word
// - crc-auto clear: all twenty bits sent straight from registers
// - reg zero bit 5 enables odd fields, bit 6 even fields, NTSC only
module vbi_caption_copy_inserter
	import vbi_pkg::*;
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              reset_n,
	// register port
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic [7:0]        regWdata,
	input  wire logic              regWr,
	input  wire logic              regRd,
	output logic [7:0]             regRdata_r,
	// encoder line timing
	input  wire logic              lineStart,
	input  wire logic [9:0]        lineNum,
	input  wire logic              oddField,
	// video path
	input  wire logic [7:0]        pixelIn,
	output logic [7:0]             videoOut_r,
	output logic                   vbiActive_r
);

	// ************************************************************
	// registers
	// ************************************************************
	logic [7:0] captionData0_r;
	logic [7:0] captionData1_r;
	logic [7:0] extData0_r;
	logic [7:0] extData1_r;
	logic [7:0] copyDataRegZero_r;
	logic [7:0] copyDataRegOne_r;
	logic [7:0] copyDataRegTwo_r;
	logic [7:0] ctrl_r;
	logic       ntscMode;
	logic       copyCrcAutoEnable;
	logic       copyOddFieldEnable;
	logic       copyEvenFieldEnable;

	assign ntscMode            = ctrl_r[CTRL_NTSC_BIT];
	assign copyCrcAutoEnable   = copyDataRegZero_r[CRC_AUTO_BIT];
	assign copyOddFieldEnable  = copyDataRegZero_r[ODD_EN_BIT];
	assign copyEvenFieldEnable = copyDataRegZero_r[EVEN_EN_BIT];

	// register writes; single buffered, so a byte written during line 20
	// is already what line 21 carries
	// single-buffer load
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			captionData0_r    <= DATA_RESET;
			captionData1_r    <= DATA_RESET;
			extData0_r        <= DATA_RESET;
			extData1_r        <= DATA_RESET;
			copyDataRegZero_r <= DATA_RESET;
			copyDataRegOne_r  <= DATA_RESET;
			copyDataRegTwo_r  <= DATA_RESET;
			ctrl_r            <= CTRL_RESET;
		end else if (regWr) begin
			case (regAddr)
				REG_CAP_DATA0: captionData0_r    <= regWdata;
				REG_CAP_DATA1: captionData1_r    <= regWdata;
				REG_EXT_DATA0: extData0_r        <= regWdata;
				REG_EXT_DATA1: extData1_r        <= regWdata;
				REG_COPY_ZERO: copyDataRegZero_r <= regWdata;
				REG_COPY_ONE:  copyDataRegOne_r  <= regWdata;
				REG_COPY_TWO:  copyDataRegTwo_r  <= regWdata;
				REG_CTRL:      ctrl_r            <= regWdata;
				default:       ctrl_r            <= ctrl_r;
			endcase
		end
	end

	// ************************************************************
	// line sequencing
	// ************************************************************
	logic [9:0]            lineNumR_r;
	logic                  fieldOdd_r;
	logic                  lineCap_r;
	logic                  lineCopy_r;
	logic [LINE_TMR_W-1:0] lineTmr_r;
	logic                  capGo;
	logic                  copyGo;
	logic                  capLineNow;
	logic                  copyLineNow;

	assign capLineNow = (lineNum == LINE_CAP_ODD && oddField) ||
		(lineNum == LINE_CAP_EVEN && !oddField);
	// copy line select, gated by mode and enables
	assign copyLineNow = ntscMode && ((lineNum == LINE_COPY_ODD && oddField &&
		copyOddFieldEnable) || (lineNum == LINE_COPY_EVEN && !oddField &&
		copyEvenFieldEnable));

	// line flags are caught once per line so a mid-line register
	// write cannot start or cut a word halfway
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			lineNumR_r <= 10'h000;
			fieldOdd_r <= 1'b0;
			lineCap_r  <= 1'b0;
			lineCopy_r <= 1'b0;
		end else if (lineStart) begin
			lineNumR_r <= lineNum;
			fieldOdd_r <= oddField;
			lineCap_r  <= capLineNow;
			lineCopy_r <= copyLineNow;
		end
	end

	// time since line start, saturating
	always_ff @(posedge clk) begin
		if (!reset_n || lineStart) lineTmr_r <= '0;
		else if (lineTmr_r != '1) lineTmr_r <= lineTmr_r + 1'b1;
	end

	assign capGo  = lineCap_r && lineTmr_r == LINE_TMR_W'(CAP_START_CYC);
	// gating looked at again at the start instant, so a
	// switch to PAL after line start still keeps the word off
	assign copyGo = lineCopy_r && ntscMode &&
		(fieldOdd_r ? copyOddFieldEnable : copyEvenFieldEnable) &&
		lineTmr_r == LINE_TMR_W'(COPY_START_CYC);

	// ************************************************************
	// words
	// ************************************************************
	logic [7:0]             capByteA;
	logic [7:0]             capByteB;
	logic [CAP_WORD_W-1:0]  capWord;
	logic [19:0]            copyRaw;
	logic [19:0]            copyBits;
	logic [5:0]             copyCrc;
	logic [COPY_WORD_W-1:0] copyWord;

	assign capByteA = fieldOdd_r ? captionData0_r : extData0_r;
	assign capByteB = fieldOdd_r ? captionData1_r : extData1_r;
	// run-in slots, two blanks, start bit, parity bytes
	assign capWord = {~^capByteB[6:0], capByteB[6:0], ~^capByteA[6:0],
		capByteA[6:0], 1'b1, 2'b00, 7'h00};

	assign copyRaw = {copyDataRegZero_r[3:0], copyDataRegOne_r, copyDataRegTwo_r};
	// crc over the low fourteen bits
	assign copyCrc = crc6(copyRaw[13:0]);
	// raw word when auto crc is off
	assign copyBits = copyCrcAutoEnable ? {copyCrc, copyRaw[13:0]} : copyRaw;
	// reference pulse ahead of the word
	assign copyWord = {copyBits, 1'b1};

	// ************************************************************
	// serialisers
	// ************************************************************
	logic       capBusy;
	logic [4:0] capIdx;
	logic [2:0] capPhase;
	logic       capBit;
	logic       copyBusy;
	logic [4:0] copyIdx;
	logic       copyBit;

	vbi_bit_sender #(.W(CAP_WORD_W), .PERIOD(CAP_BIT_CYC)) capSender (
		.clk     (clk),
		.reset_n (reset_n),
		.start   (capGo),
		.bits    (capWord),
		.busy_r  (capBusy),
		.idx_r   (capIdx),
		.phase_r (capPhase),
		.curBit  (capBit)
	);

	// copy word serialised from bit zero
	vbi_bit_sender #(.W(COPY_WORD_W), .PERIOD(COPY_BIT_CYC)) copySender (
		.clk     (clk),
		.reset_n (reset_n),
		.start   (copyGo),
		.bits    (copyWord),
		.busy_r  (copyBusy),
		.idx_r   (copyIdx),
		.phase_r (),
		.curBit  (copyBit)
	);

	// ************************************************************
	// video output
	// ************************************************************
	// pixels replaced for the whole inserted line
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			videoOut_r  <= LVL_BLANK;
			vbiActive_r <= 1'b0;
		end else if (capBusy && capIdx < 5'(RUNIN_BITS)) begin
			videoOut_r  <= sine_level(capPhase);
			vbiActive_r <= 1'b1;
		end else if (capBusy) begin
			videoOut_r  <= capBit ? LVL_CAP_HIGH : LVL_BLANK;
			vbiActive_r <= 1'b1;
		end else if (copyBusy) begin
			videoOut_r  <= copyBit ? LVL_COPY_HIGH : LVL_BLANK;
			vbiActive_r <= 1'b1;
		end else if (lineCap_r || lineCopy_r) begin
			videoOut_r  <= LVL_BLANK;
			vbiActive_r <= 1'b1;
		end else begin
			videoOut_r  <= pixelIn;
			vbiActive_r <= 1'b0;
		end
	end

	// read port: data stand in the cycle after the strobe only
	always_ff @(posedge clk) begin
		if (!reset_n || !regRd) regRdata_r <= 8'h00;
		else begin
			case (regAddr)
				REG_CAP_DATA0: regRdata_r <= captionData0_r;
				REG_CAP_DATA1: regRdata_r <= captionData1_r;
				REG_EXT_DATA0: regRdata_r <= extData0_r;
				REG_EXT_DATA1: regRdata_r <= extData1_r;
				REG_COPY_ZERO: regRdata_r <= copyDataRegZero_r;
				REG_COPY_ONE:  regRdata_r <= copyDataRegOne_r;
				REG_COPY_TWO:  regRdata_r <= copyDataRegTwo_r;
				REG_CTRL:      regRdata_r <= ctrl_r;
				REG_STATUS:    regRdata_r <= {5'h00, fieldOdd_r, copyBusy, capBusy};
				default:       regRdata_r <= 8'h00;
			endcase
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	cap_line_a: assert property (@(posedge clk) disable iff (!reset_n)
		capGo |-> (lineNumR_r == LINE_CAP_ODD && fieldOdd_r) ||
			(lineNumR_r == LINE_CAP_EVEN && !fieldOdd_r))
		else $error("caption started on a wrong line");

	runin_sine_a: assert property (@(posedge clk) disable iff (!reset_n)
		capBusy && capIdx < 5'(RUNIN_BITS) |=> videoOut_r == sine_level($past(capPhase)))
		else $error("run-in level not taken from sine");

	start_bit_a: assert property (@(posedge clk) disable iff (!reset_n)
		capBusy && capIdx >= 5'd7 && capIdx <= 5'd9 |=>
			videoOut_r == ($past(capIdx) == 5'd9 ? LVL_CAP_HIGH : LVL_BLANK))
		else $error("blank pair or start bit wrong");

	odd_parity_a: assert property (@(posedge clk) disable iff (!reset_n)
		capGo |=> ##1 capBusy && (^capWord[17:10]) && (^capWord[25:18]))
		else $error("caption byte parity not odd");

	ext_source_a: assert property (@(posedge clk) disable iff (!reset_n)
		capGo && !fieldOdd_r |-> capWord[16:10] == extData0_r[6:0] &&
			capWord[24:18] == extData1_r[6:0])
		else $error("even field bytes not from extended registers");

	pixel_ignore_a: assert property (@(posedge clk) disable iff (!reset_n)
		lineCap_r && !capBusy && !lineStart |=> videoOut_r == LVL_BLANK)
		else $error("pixel data leaked into caption line");

	buffer_load_a: assert property (@(posedge clk) disable iff (!reset_n)
		regWr && regAddr == REG_CAP_DATA0 |=> captionData0_r == $past(regWdata))
		else $error("caption byte not loaded");

	copy_ntsc_a: assert property (@(posedge clk) disable iff (!reset_n)
		copyGo |-> ntscMode && (fieldOdd_r ? copyOddFieldEnable : copyEvenFieldEnable))
		else $error("copy word without NTSC or enable");

	ref_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
		copyBusy && copyIdx == 5'd0 && !capBusy |=> videoOut_r == LVL_COPY_HIGH)
		else $error("reference pulse missing");

	crc_auto_a: assert property (@(posedge clk) disable iff (!reset_n)
		copyGo && copyCrcAutoEnable |-> copyWord[20:15] == crc6(copyRaw[13:0]))
		else $error("auto crc not inserted");

	crc_off_a: assert property (@(posedge clk) disable iff (!reset_n)
		copyGo && !copyCrcAutoEnable |-> copyWord[20:1] == {copyDataRegZero_r[3:0],
			copyDataRegOne_r, copyDataRegTwo_r})
		else $error("raw copy bits altered");

	cap_odd_c: cover property (@(posedge clk) capGo && fieldOdd_r);
	cap_even_c: cover property (@(posedge clk) capGo && !fieldOdd_r);
	copy_crc_c: cover property (@(posedge clk) copyGo && copyCrcAutoEnable);
	copy_even_c: cover property (@(posedge clk) copyGo && !fieldOdd_r);

endmodule // vbi_caption_copy_inserter

// ### tb/vbi_caption_receiver.sv
`timescale 1ns/1ps
module vbi_caption_receiver import vbi_pkg::*; (
	// clock
	input  wire logic        clk,
	// line timing and video seen by the set
	input  wire logic        lineStart,
	input  wire logic [7:0]  videoOut,
	input  wire logic        vbiActive,
	// decoded results of the last line
	output logic [25:0]      capWord_r,
	output logic [20:0]      copyWord_r,
	output logic [3:0]       peakCnt_r,
	output logic             activeSeen_r,
	output logic [7:0]       earlyVideo_r
);
	// ************************************************************
	// slicer timing: sample each bit at its centre
	// ************************************************************
	localparam int CAP0  = CAP_START_CYC + 3 + CAP_BIT_CYC / 2;
	localparam int COPY0 = COPY_START_CYC + 3 + COPY_BIT_CYC / 2;
	localparam int RUNIN_END = CAP0 + RUNIN_BITS * CAP_BIT_CYC - CAP_BIT_CYC / 2;

	int   cnt_r;
	int   capOff;
	int   copyOff;
	logic wasHigh_r;

	assign capOff  = cnt_r - CAP0;
	assign copyOff = cnt_r - COPY0;

	// line counter restarts on each line pulse
	always_ff @(posedge clk) begin
		cnt_r <= lineStart ? 1 : cnt_r + 1;
	end

	// slice bits
	// one threshold for both words: 8'h40 sits between blank and either high level
	always_ff @(posedge clk) begin
		if (capOff >= 0 && capOff % CAP_BIT_CYC == 0 && capOff / CAP_BIT_CYC < CAP_WORD_W)
			capWord_r[capOff / CAP_BIT_CYC] <= videoOut > 8'h40;
		if (copyOff >= 0 && copyOff % COPY_BIT_CYC == 0 && copyOff / COPY_BIT_CYC < COPY_WORD_W)
			copyWord_r[copyOff / COPY_BIT_CYC] <= videoOut > 8'h40;
	end

	always_ff @(posedge clk) begin
		wasHigh_r <= videoOut == LVL_CAP_HIGH;
		if (lineStart)
			peakCnt_r <= 4'h0;
		else if (cnt_r < RUNIN_END && videoOut == LVL_CAP_HIGH && !wasHigh_r)
			peakCnt_r <= peakCnt_r + 4'h1;
	end

	// early look at the line, well before any word
	always_ff @(posedge clk) begin
		if (cnt_r == 100) begin
			activeSeen_r <= vbiActive;
			earlyVideo_r <= videoOut;
		end
	end
endmodule // vbi_caption_receiver

// ### tb/vbi_caption_copy_inserter_tb_top.sv
`timescale 1ns/1ps
module vbi_caption_copy_inserter_tb_top import vbi_pkg::*;;
	localparam int LINE_CYC = 8000;
	localparam int CEILING  = 70000;

	logic                clk;
	logic                reset_n;
	logic [ADDR_W-1:0]   regAddr;
	logic [7:0]          regWdata;
	logic                regWr;
	logic                regRd;
	logic [7:0]          regRdata_r;
	logic                lineStart;
	logic [9:0]          lineNum;
	logic                oddField;
	logic [7:0]          pixelIn;
	logic [7:0]          videoOut_r;
	logic                vbiActive_r;
	logic [25:0]         capWord;
	logic [20:0]         copyWord;
	logic [3:0]          peakCnt;
	logic                activeSeen;
	logic [7:0]          earlyVideo;
	int                  miscompares;
	int                  testsRun;
	int                  cycles;

	vbi_caption_copy_inserter dut_u (
		.clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata_r(regRdata_r), .lineStart(lineStart),
		.lineNum(lineNum), .oddField(oddField), .pixelIn(pixelIn),
		.videoOut_r(videoOut_r), .vbiActive_r(vbiActive_r)
	);

	vbi_caption_receiver rx_u (
		.clk(clk), .lineStart(lineStart), .videoOut(videoOut_r), .vbiActive(vbiActive_r),
		.capWord_r(capWord), .copyWord_r(copyWord), .peakCnt_r(peakCnt),
		.activeSeen_r(activeSeen), .earlyVideo_r(earlyVideo)
	);

	// ************************************************************
	// clock, timeout and reporting
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// a hung run is cut short and reported as a failure
	always @(posedge clk) begin
		cycles++;
		if (cycles == CEILING) begin
			miscompares++;
			test_done();
		end
	end

	task automatic test_done();
		$display("compares %0d mismatches %0d", testsRun, miscompares);
		if (miscompares == 0 && testsRun > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		testsRun++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// ************************************************************
	// bus and line drivers
	// ************************************************************
	// one idle edge after each strobe so no strobe is driven twice in a step
	task automatic wrReg(input logic [3:0] a, input logic [7:0] d);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rdChk(input logic [3:0] a, input logic [7:0] exp);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		chk($sformatf("reg %0h", a), exp, regRdata_r);
		@(posedge clk);
	endtask

	task automatic runLine(input logic [9:0] n, input logic odd);
		lineStart <= 1'b1;
		lineNum <= n;
		oddField <= odd;
		@(posedge clk);
		lineStart <= 1'b0;
		repeat (LINE_CYC - 1) @(posedge clk);
	endtask

	// ************************************************************
	// expected words
	// ************************************************************
	// data part of a caption word, from the first blank bit on
	function automatic logic [18:0] capExp(input logic [7:0] a, input logic [7:0] b);
		return {~^b[6:0], b[6:0], ~^a[6:0], a[6:0], 1'b1, 2'b00};
	endfunction

	function automatic logic [20:0] copyExp(input logic [7:0] z, input logic [7:0] o,
			input logic [7:0] t);
		logic [19:0] c;
		logic [5:0]  s;
		logic        f;
		c = {z[3:0], o, t};
		if (z[CRC_AUTO_BIT]) begin
			s = 6'h3f;
			for (int i = 0; i < 14; i++) begin
				f = s[5] ^ c[i];
				s = {s[4:0], 1'b0} ^ {4'h0, f, f};
			end
			c[19:14] = s;
		end
		return {c, 1'b1};
	endfunction

	// a line the block must leave alone
	task automatic idleChk(input string name);
		chk({name, " active"}, 32'h0, activeSeen);
		chk({name, " video"}, 32'ha5, earlyVideo);
		$display("test %s done", name);
	endtask

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		reset_n = 1'b0;
		regAddr = '0;
		regWdata = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
		lineStart = 1'b0;
		lineNum = 10'h000;
		oddField = 1'b0;
		pixelIn = 8'ha5;
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		rdChk(REG_CTRL, CTRL_RESET);
		rdChk(REG_CAP_DATA0, DATA_RESET);
		for (int a = 0; a < 7; a++) begin
			wrReg(a[3:0], 8'h55 + a[7:0]);
			rdChk(a[3:0], 8'h55 + a[7:0]);
		end
		wrReg(4'hf, 8'h3c);
		rdChk(4'hf, 8'h00);
		$display("test registers done");

		// odd field: copy with crc, then caption loaded just before
		wrReg(REG_COPY_ZERO, 8'h3a);
		wrReg(REG_COPY_ONE, 8'h5c);
		wrReg(REG_COPY_TWO, 8'ha7);
		wrReg(REG_CAP_DATA0, 8'hc1);
		wrReg(REG_CAP_DATA1, 8'h13);
		runLine(LINE_COPY_ODD, 1'b1);
		chk("copy odd", copyExp(8'h3a, 8'h5c, 8'ha7), copyWord);
		chk("copy odd active", 32'h1, activeSeen);
		runLine(LINE_CAP_ODD, 1'b1);
		chk("caption odd", capExp(8'hc1, 8'h13), capWord[25:7]);
		chk("run-in", RUNIN_BITS, peakCnt);
		chk("pixels held", LVL_BLANK, earlyVideo);
		chk("caption active", 32'h1, activeSeen);
		rdChk(REG_STATUS, 8'h04);
		$display("test odd field done");

		// even field: raw copy word and extended caption
		wrReg(REG_COPY_ZERO, 8'h4b);
		wrReg(REG_EXT_DATA0, 8'h7f);
		wrReg(REG_EXT_DATA1, 8'h80);
		runLine(LINE_COPY_EVEN, 1'b0);
		chk("copy even", copyExp(8'h4b, 8'h5c, 8'ha7), copyWord);
		runLine(LINE_CAP_EVEN, 1'b0);
		chk("caption even", capExp(8'h7f, 8'h80), capWord[25:7]);
		rdChk(REG_STATUS, 8'h00);
		$display("test even field done");

		// gating: odd enable clear, then pal mode with both enables
		runLine(LINE_COPY_ODD, 1'b1);
		idleChk("odd gated");
		wrReg(REG_CTRL, 8'h00);
		wrReg(REG_COPY_ZERO, 8'h6b);
		runLine(LINE_COPY_EVEN, 1'b0);
		idleChk("pal");
		wrReg(REG_CTRL, CTRL_RESET);

		// nulled bytes; line 21 in the wrong field stays untouched
		wrReg(REG_CAP_DATA0, 8'h00);
		wrReg(REG_CAP_DATA1, 8'h00);
		runLine(LINE_CAP_ODD, 1'b0);
		idleChk("wrong field");
		runLine(LINE_CAP_ODD, 1'b1);
		chk("caption null", capExp(8'h00, 8'h00), capWord[25:7]);
		$display("test null done");
		test_done();
	end
endmodule // vbi_caption_copy_inserter_tb_top
